// >>> verilog/sia_pkg.sv
// Constants for the switch input configuration and readout block.
// Assumes a 100 MHz reference clock and a 24-bit serial command frame.
//
// Operation
// - Metallic inputs get high wetting current only for 20 ms after closing.
// - Wetting timer disabled keeps high current while the contact stays closed.
// - Contact-type command selects high or low current level per input.
// - Analog-select codes 1 to 22 pick one of the 22 inputs; any other code picks none.
// - New analog selection takes effect at chip-select rising edge only.
// - Analog-selected input reports zero in following status frames.
// - Analog input bias is high impedance, low pull-up or high pull-up.
// - After reset every input is tri-stated and the device runs normally.
// - Switch-to-battery programmable input, not tri-stated, sinks current.
// - Switch-to-ground programmable input, not tri-stated, sources current.
// - Ground-sense input source follows its tri-state setting.
// - Ground-sense input pin low reports one, even while tri-stated.
// - Masked inputs raise no interrupt on state change.
// - Configuration commands are accepted over the serial link.
// - Over-temperature forces low current level and raises an interrupt.
// - Interrupt stays asserted until a completed serial read acknowledges it.
package sia_pkg;

   localparam int          NUM_IN      = 22;
   localparam int          NUM_SG      = 14;
   localparam int          NUM_SP      = 8;
   localparam int          FRAME_BITS  = 24;

   // Wetting window in milliseconds and the clock rate in kilohertz.
   localparam int unsigned WET_MS      = 20;
   localparam int unsigned CLK_KHZ     = 100000;

   // Command codes in frame bits 23:16.
   localparam logic [7:0]  CMD_STATUS  = 8'h00;
   localparam logic [7:0]  CMD_DIR     = 8'h01;
   localparam logic [7:0]  CMD_WAKE    = 8'h03;
   localparam logic [7:0]  CMD_METAL   = 8'h04;
   localparam logic [7:0]  CMD_ANALOG  = 8'h05;
   localparam logic [7:0]  CMD_WETTMR  = 8'h06;
   localparam logic [7:0]  CMD_TRI     = 8'h07;

   // Field positions.
   localparam int          CMD_MSB     = 23;
   localparam int          CMD_LSB     = 16;
   localparam int          SO_THERM    = 23;
   localparam int          SO_INT      = 22;
   localparam int          AN_BIAS_LSB = 5;

   // Analog bias options.
   localparam logic [1:0]  BIAS_HIZ    = 2'h0;
   localparam logic [1:0]  BIAS_LOW    = 2'h1;
   localparam logic [1:0]  BIAS_HIGH   = 2'h2;

   // Values after reset.
   localparam logic [21:0] RST_TRI     = 22'h3fffff;
   localparam logic [21:0] RST_METAL   = 22'h3fffff;
   localparam logic [21:0] RST_WETTMR  = 22'h3fffff;
   localparam logic [21:0] RST_WAKE    = 22'h3fffff;
   localparam logic [7:0]  RST_DIR     = 8'h00;
   localparam logic [4:0]  RST_ANALOG_SELECT_OUTPUT    = 5'h00;
   localparam logic [1:0]  RST_BIAS    = 2'h0;

endpackage

// >>> verilog/sia_top.sv
// Switch input configuration, current drive, analog select and readout.
// Assumes serial pins are already synchronous to REF_CLK and that
// comparator inputs are high when the pin is above the threshold.
`timescale 1ns/1ns
`default_nettype none
module sia_top #(
   parameter int unsigned WET_CYCLES = sia_pkg::WET_MS * sia_pkg::CLK_KHZ
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        CS_N,
   input  wire logic        SCLK,
   input  wire logic        SI,
   output logic             SO,
   output logic             SO_OE,
   input  wire logic [13:0] GND_SENSE_ABOVE,
   input  wire logic [7:0]  PROG_ABOVE,
   input  wire logic        OVER_TEMP,
   output logic             INT_N,
   output logic [21:0]      SOURCE_ON,
   output logic [21:0]      SINK_ON,
   output logic [21:0]      HIGH_LEVEL,
   output logic [4:0]       ANALOG_SELECT_OUTPUT,
   output logic             ANALOG_EN
);

   ////////////////////////////////////////////////////////////////////////
   // Analog code decode, used for readout masking and for bias.

   function automatic logic [21:0] an_onehot(input logic [4:0] code);
      logic [21:0] v;
      v = 22'h000000;
      for (int i = 0; i < sia_pkg::NUM_IN; i++) begin
         if (code == 5'(i + 1)) begin
            v[i] = 1'b1;
         end
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Serial frame handling.

   logic        cs_prev_reg;
   logic        sclk_prev_reg;
   logic [23:0] rx_reg;
   logic [23:0] tx_reg;
   logic [4:0]  bit_cnt_reg;
   logic        so_oe_reg;
   logic        cs_fall;
   logic        cs_rise;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        frame_ok;

   assign cs_fall   = cs_prev_reg & ~CS_N;
   assign cs_rise   = ~cs_prev_reg & CS_N;
   assign sclk_rise = ~sclk_prev_reg & SCLK & ~CS_N;
   assign sclk_fall = sclk_prev_reg & ~SCLK & ~CS_N;
   assign frame_ok  = cs_rise && (bit_cnt_reg == 5'(sia_pkg::FRAME_BITS));

   logic [21:0] tri_reg;
   logic [21:0] metal_reg;
   logic [21:0] wettmr_reg;
   logic [21:0] wake_reg;
   logic [7:0]  dir_reg;
   logic [4:0]  analog_select_output_reg;
   logic [1:0]  bias_reg;
   logic        therm_reg;
   logic        pend_reg;
   logic [21:0] status_now;
   logic [21:0] status_prev_reg;
   logic [21:0] an_sel;

   assign an_sel = an_onehot(analog_select_output_reg);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cs_prev_reg   <= 1'b1;
         sclk_prev_reg <= 1'b0;
         so_oe_reg     <= 1'b0;
      end else begin
         cs_prev_reg   <= CS_N;
         sclk_prev_reg <= SCLK;
         so_oe_reg     <= ~CS_N;
      end
   end

   // The counter saturates so an over-long frame never wraps back to 24.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_reg      <= 24'h000000;
         bit_cnt_reg <= 5'h00;
      end else if (cs_fall) begin
         bit_cnt_reg <= 5'h00;
      end else if (sclk_rise) begin
         rx_reg <= {rx_reg[22:0], SI};
         if (bit_cnt_reg != 5'h1f) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
      end
   end

   // Status is snapshotted at frame start so the word stays stable.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tx_reg <= 24'h000000;
      end else if (cs_fall) begin
         tx_reg <= {therm_reg, pend_reg, status_now & ~an_sel};
      end else if (sclk_fall) begin
         tx_reg <= {tx_reg[22:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration, applied only when a full frame ends.
   // Command bits 21:16 overlap the data field, so the host must allow for it.

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         tri_reg    <= sia_pkg::RST_TRI;
         metal_reg  <= sia_pkg::RST_METAL;
         wettmr_reg <= sia_pkg::RST_WETTMR;
         wake_reg   <= sia_pkg::RST_WAKE;
         dir_reg    <= sia_pkg::RST_DIR;
         analog_select_output_reg   <= sia_pkg::RST_ANALOG_SELECT_OUTPUT;
         bias_reg   <= sia_pkg::RST_BIAS;
      end else if (frame_ok) begin
         unique case (rx_reg[sia_pkg::CMD_MSB:sia_pkg::CMD_LSB])
            sia_pkg::CMD_DIR: begin
               dir_reg <= rx_reg[21:14];
            end
            sia_pkg::CMD_WAKE: begin
               wake_reg <= rx_reg[21:0];
            end
            sia_pkg::CMD_METAL: begin
               metal_reg <= rx_reg[21:0];
            end
            sia_pkg::CMD_ANALOG: begin
               analog_select_output_reg <= rx_reg[4:0];
               bias_reg <= rx_reg[sia_pkg::AN_BIAS_LSB +: 2];
            end
            sia_pkg::CMD_WETTMR: begin
               wettmr_reg <= rx_reg[21:0];
            end
            sia_pkg::CMD_TRI: begin
               tri_reg <= rx_reg[21:0];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Switch state sensing.

   // Ground-sense comparators run regardless of tri-state.
   assign status_now[13:0]  = ~GND_SENSE_ABOVE;
   // Programmable status follows the drive direction of each input.
   assign status_now[21:14] = dir_reg ^ ~PROG_ABOVE;

   logic [21:0] changed;
   logic        therm_prev_reg;
   logic        late_reg;
   logic        event_now;

   assign changed   = (status_now ^ status_prev_reg) & wake_reg;
   assign event_now = (|changed) | (OVER_TEMP & ~therm_prev_reg);

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         status_prev_reg <= 22'h000000;
         therm_prev_reg  <= 1'b0;
      end else begin
         status_prev_reg <= status_now;
         therm_prev_reg  <= OVER_TEMP;
      end
   end

   // A change while the frame is open survives its acknowledge.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         late_reg <= 1'b0;
      end else if (cs_fall) begin
         late_reg <= event_now;
      end else if (!CS_N && event_now) begin
         late_reg <= 1'b1;
      end
   end

   // Set wins over the acknowledge so no event is lost at a frame end.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pend_reg <= 1'b0;
      end else if (event_now) begin
         pend_reg <= 1'b1;
      end else if (frame_ok) begin
         pend_reg <= late_reg;
      end
   end

   // The thermal flag needs a frame end after cooling before it clears.
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         therm_reg <= 1'b0;
      end else if (OVER_TEMP) begin
         therm_reg <= 1'b1;
      end else if (cs_rise) begin
         therm_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wetting timers, one per input.

   logic [21:0] wet_active;

   for (genvar g = 0; g < sia_pkg::NUM_IN; g++) begin : g_wet
      logic [21:0] cnt_reg;
      always_ff @(posedge REF_CLK or negedge RST_N) begin
         if (!RST_N) begin
            cnt_reg <= 22'h000000;
         end else if (!status_now[g]) begin
            cnt_reg <= 22'h000000;
         end else if (!status_prev_reg[g]) begin
            cnt_reg <= 22'(WET_CYCLES - 1);
         end else if (cnt_reg != 22'h000000) begin
            cnt_reg <= cnt_reg - 22'h000001;
         end
      end
      // The closing cycle counts as wetting, so no low-level gap appears.
      assign wet_active[g] = status_now[g] &&
                             (!wettmr_reg[g] || !status_prev_reg[g] ||
                              cnt_reg != 22'h000000);
   end

   ////////////////////////////////////////////////////////////////////////
   // Current source drive outputs.

   logic [21:0] source_next;
   logic [21:0] sink_next;
   logic [21:0] high_next;
   logic [21:0] prog_mask;

   assign prog_mask = {{sia_pkg::NUM_SP{1'b1}}, {sia_pkg::NUM_SG{1'b0}}};

   always_comb begin
      logic [21:0] batt;
      batt        = {dir_reg, 14'h0000} & prog_mask;
      sink_next   = ~tri_reg & batt;
      source_next = ~tri_reg & ~batt;
      high_next   = metal_reg & wet_active;
      for (int i = 0; i < sia_pkg::NUM_IN; i++) begin
         if (an_sel[i]) begin
            sink_next[i]   = 1'b0;
            source_next[i] = (bias_reg != sia_pkg::BIAS_HIZ);
            high_next[i]   = (bias_reg == sia_pkg::BIAS_HIGH);
         end
      end
      if (OVER_TEMP) begin
         high_next = 22'h000000;
      end
   end

   logic [21:0] source_reg;
   logic [21:0] sink_reg;
   logic [21:0] high_reg;
   logic        int_n_reg;
   logic [4:0]  analog_select_output_out_reg;
   logic        an_en_reg;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         source_reg   <= 22'h000000;
         sink_reg     <= 22'h000000;
         high_reg     <= 22'h000000;
         int_n_reg    <= 1'b1;
         analog_select_output_out_reg <= sia_pkg::RST_ANALOG_SELECT_OUTPUT;
         an_en_reg    <= 1'b0;
      end else begin
         source_reg   <= source_next;
         sink_reg     <= sink_next;
         // Level means nothing on an undriven input, so it is masked.
         high_reg     <= high_next & (source_next | sink_next);
         int_n_reg    <= ~pend_reg;
         analog_select_output_out_reg <= (|an_sel) ? analog_select_output_reg : 5'h00;
         an_en_reg    <= |an_sel;
      end
   end

   // Tx shift bit 23 is a flip-flop, so SO needs no extra stage.
   assign SO                   = tx_reg[23];
   assign SO_OE                = so_oe_reg;
   assign INT_N                = int_n_reg;
   assign SOURCE_ON            = source_reg;
   assign SINK_ON              = sink_reg;
   assign HIGH_LEVEL           = high_reg;
   assign ANALOG_SELECT_OUTPUT = analog_select_output_out_reg;
   assign ANALOG_EN            = an_en_reg;

endmodule // sia_top
`default_nettype wire

// >>> bench/sia_checker.sv
// Port assertions for the switch input block.
// Assumes it is bound into sia_top and clocked by REF_CLK.
`timescale 1ns/1ns
`default_nettype none
module sia_checker #(
   parameter int unsigned WET_CYCLES = 50
) (
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic        CS_N,
   input wire logic        SO_OE,
   input wire logic        OVER_TEMP,
   input wire logic        INT_N,
   input wire logic [21:0] SOURCE_ON,
   input wire logic [21:0] SINK_ON,
   input wire logic [21:0] HIGH_LEVEL,
   input wire logic [4:0]  ANALOG_SELECT_OUTPUT,
   input wire logic        ANALOG_EN
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////
   // Drive moves only two cycles after a frame closes, never mid frame.
   a_drive_frame_end: assert property (
      ($changed(SOURCE_ON) || $changed(SINK_ON))
      |-> $past(CS_N, 2) && !$past(CS_N, 3))
      else $error("drive moved mid frame");
   a_analog_select_output_frame_end: assert property (
      !$stable(ANALOG_SELECT_OUTPUT) |-> $past(CS_N, 2) && !$past(CS_N, 3))
      else $error("analog select moved mid frame");
   a_analog_select_output_code: assert property (
      ANALOG_EN ? ANALOG_SELECT_OUTPUT inside {[5'h01:5'h16]}
      : ANALOG_SELECT_OUTPUT == 5'h00) else $error("analog code out of range");
   a_sink_prog_only: assert property (SINK_ON[13:0] == 14'h0000)
      else $error("ground sense input sinking");
   a_no_fight: assert property ((SOURCE_ON & SINK_ON) == 22'h000000)
      else $error("source and sink both on");
   a_temp_int: assert property ($rose(OVER_TEMP) |-> ##[1:4] !INT_N)
      else $error("no interrupt on over temperature");
   a_temp_level: assert property (OVER_TEMP [*4] |-> HIGH_LEVEL == '0)
      else $error("high level kept while hot");
   // A rising interrupt line must follow a frame that just closed.
   a_int_ack: assert property (
      $rose(INT_N) |-> !($past(CS_N, 3) && $past(CS_N, 4) && $past(CS_N, 5)
      && $past(CS_N, 6))) else $error("interrupt cleared without a frame");
   a_so_oe_on: assert property ($fell(CS_N) |-> ##1 SO_OE ##1 SO_OE)
      else $error("serial output not enabled");
endmodule // sia_checker
bind sia_top sia_checker #(.WET_CYCLES(WET_CYCLES)) i_sia_checker (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .CS_N(CS_N), .SO_OE(SO_OE),
   .OVER_TEMP(OVER_TEMP), .INT_N(INT_N), .SOURCE_ON(SOURCE_ON),
   .SINK_ON(SINK_ON), .HIGH_LEVEL(HIGH_LEVEL),
   .ANALOG_SELECT_OUTPUT(ANALOG_SELECT_OUTPUT), .ANALOG_EN(ANALOG_EN));
`default_nettype wire

// >>> bench/sia_host.sv
// Host model: serial master that sends whole 24-bit frames.
// Assumes SCLK is oversampled by the block, so each phase spans cycles.
`timescale 1ns/1ns
`default_nettype none
module sia_host (
   input  wire logic clk,
   output logic      cs_n,
   output logic      sclk,
   output logic      si,
   input  wire logic so
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end
   ////////////////////////////////////////
   // SO is taken just before SCLK rises, when it has settled.
   task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
      @(posedge clk) cs_n <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 23; i >= 0; i--) begin
         si <= tx[i];
         repeat (3) @(posedge clk);
         rx[i] = so;
         sclk <= 1'b1;
         repeat (2) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (2) @(posedge clk);
      cs_n <= 1'b1;
      si <= ~tx[0];
      repeat (2) @(posedge clk);
   endtask
endmodule // sia_host
`default_nettype wire

// >>> bench/sia_top_tb_top.sv
// Self-checking bench for sia_top driven by the serial host model.
// Assumes a short wetting window through WET_CYCLES.
`timescale 1ns/1ns
`default_nettype none
module sia_top_tb_top;
   localparam int unsigned WET = 50;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        over_temp = 1'b0;
   logic        cs_n, sclk, si, so, so_oe, int_n, an_en;
   logic [13:0] gnd = 14'h3fff;
   logic [7:0]  prog = 8'hff;
   logic [21:0] src, snk, hi;
   logic [4:0]  analog_select_output;
   logic [23:0] rx;
   int          n_fail = 0;
   int          checked = 0;
   int          cyc = 0;

   always #5 ref_clk = ~ref_clk;

   sia_top #(.WET_CYCLES(WET)) i_sia_top (
      .REF_CLK(ref_clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .SI(si),
      .SO(so), .SO_OE(so_oe), .GND_SENSE_ABOVE(gnd), .PROG_ABOVE(prog),
      .OVER_TEMP(over_temp), .INT_N(int_n), .SOURCE_ON(src), .SINK_ON(snk),
      .HIGH_LEVEL(hi), .ANALOG_SELECT_OUTPUT(analog_select_output), .ANALOG_EN(an_en));
   sia_host i_sia_host (.clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si),
      .so(so));
   ////////////////////////////////////////
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // A hang costs a mismatch rather than an endless run.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end
   ////////////////////////////////////////
   task automatic t_tri;
      i_sia_host.xfer({sia_pkg::CMD_TRI, 16'h0007}, rx);
      wt(4);
      chk(src, 22'h38fff8);
      chk(snk, 22'h0);
   endtask
   task automatic t_dir;
      i_sia_host.xfer({sia_pkg::CMD_DIR, 16'hc000}, rx);
      wt(6);
      chk(snk, 22'h00c000);
      chk(src, 22'h383ff8);
      chk(hi & 22'h00c000, 22'h00c000);
      chk(int_n, 1'b0);
      wt(WET + 10);
      chk(hi & 22'h00c000, 22'h0);
      chk(int_n, 1'b0);
   endtask
   task automatic t_wet_temp;
      i_sia_host.xfer({sia_pkg::CMD_WETTMR, 16'h0000}, rx);
      wt(6);
      chk(hi & 22'h00c000, 22'h00c000);
      chk(int_n, 1'b1);
      @(posedge ref_clk) over_temp <= 1'b1;
      wt(6);
      chk(hi, 22'h0);
      chk(int_n, 1'b0);
      @(posedge ref_clk) over_temp <= 1'b0;
      wt(6);
      chk(hi & 22'h00c000, 22'h00c000);
      i_sia_host.xfer({sia_pkg::CMD_METAL, 16'h4000}, rx);
      wt(4);
      chk(hi & 22'h00c000, 22'h004000);
   endtask
   task automatic t_analog;
      @(posedge ref_clk) gnd[0] <= 1'b0;
      wt(4);
      i_sia_host.xfer({sia_pkg::CMD_STATUS, 16'h0000}, rx);
      chk(rx[21:0], 22'h01c001);
      chk(rx[23:22], 2'h1);
      for (int b = 0; b < 3; b++) begin
         i_sia_host.xfer({sia_pkg::CMD_ANALOG, 9'h000, 2'(b), 5'h01}, rx);
         wt(4);
         chk(analog_select_output, 5'h01);
         chk(an_en, 1'b1);
         chk(src[0], b != 0);
         if (b != 0) chk(hi[0], b == 2);
      end
      i_sia_host.xfer({sia_pkg::CMD_STATUS, 16'h0000}, rx);
      chk(rx[0], 1'b0);
      i_sia_host.xfer({sia_pkg::CMD_ANALOG, 16'h0016}, rx);
      wt(4);
      chk(analog_select_output, 5'h16);
   endtask
   task automatic t_mask;
      i_sia_host.xfer({sia_pkg::CMD_WAKE, 16'hfffd}, rx);
      i_sia_host.xfer({sia_pkg::CMD_STATUS, 16'h0000}, rx);
      wt(6);
      chk(int_n, 1'b1);
      @(posedge ref_clk) gnd[1] <= 1'b0;
      wt(8);
      chk(int_n, 1'b1);
      @(posedge ref_clk) gnd[3] <= 1'b0;
      wt(8);
      chk(int_n, 1'b0);
   endtask
   ////////////////////////////////////////
   initial begin
      wt(2);
      rst_n <= 1'b1;
      wt(3);
      chk(src, 22'h0);
      chk(snk, 22'h0);
      chk(int_n, 1'b1);
      t_tri();
      t_dir();
      t_wet_temp();
      t_analog();
      t_mask();
      print_verdict();
   end
endmodule // sia_top_tb_top
`default_nettype wire
